// [verilog/ffp_device.sv]
`timescale 1ns/1ps
`default_nettype none
module ffp_device
  import ffp_pkg::*;
#(
  parameter int DW     = 16,
  parameter int AW     = 32,
  parameter int DEPTH  = 2,
  parameter int NUM_IO = 8
) (
  input  wire logic          MCLK,
  input  wire logic          RESET_N,
  ffp_if.device              LINK,
  input  wire logic          EXT_CLOCK_IN,
  output logic               CLK_SEL_EXT,
  output logic [NUM_IO-1:0]  IO_PULLUP_EN,
  output logic [NUM_IO-1:0]  IO_OE,
  output ffp_op_t            CMD_OP,
  output logic [DW-1:0]      CMD_WORD,
  output logic               OP_VALID,
  input  wire logic          OP_READY,
  output ffp_op_t            OP_CODE,
  output logic [AW-1:0]      OP_ADDR,
  output logic [DW-1:0]      OP_DATA,
  output logic               RD_REQ,
  output ffp_op_t            RD_OP,
  output logic [AW-1:0]      RD_ADDR,
  input  wire logic          RD_ACK,
  input  wire logic [DW-1:0] RD_DATA
);

  typedef enum logic [2:0] {
    D_IDLE    = 3'b000,
    D_EXEC    = 3'b001,
    D_RD_OE   = 3'b010,
    D_RD_WAIT = 3'b011,
    D_RD_DRV  = 3'b100,
    D_WAIT_HI = 3'b101
  } ffp_dstate_t;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int EW = 5 + AW + DW;

  function automatic ffp_op_t ffp_decode(input logic [15:0] w);
    case (w)
      CMD_READ:        ffp_decode = OP_READ;
      CMD_WRITE_PAGE:  ffp_decode = OP_WRITE_PAGE;
      CMD_WP_LOCK:     ffp_decode = OP_WRITE_PAGE_LOCK;
      CMD_ERASE_WP:    ffp_decode = OP_ERASE_WRITE;
      CMD_ERASE_WP_LK: ffp_decode = OP_ERASE_WRITE_LK;
      CMD_ERASE_ALL:   ffp_decode = OP_ERASE_ALL;
      CMD_SET_LOCK:    ffp_decode = OP_SET_LOCK;
      CMD_CLEAR_LOCK:  ffp_decode = OP_CLEAR_LOCK;
      CMD_GET_LOCK:    ffp_decode = OP_GET_LOCK;
      CMD_SET_CONFIG:  ffp_decode = OP_SET_CONFIG;
      CMD_CLR_CONFIG:  ffp_decode = OP_CLEAR_CONFIG;
      CMD_GET_CONFIG:  ffp_decode = OP_GET_CONFIG;
      CMD_SET_SECURE:  ffp_decode = OP_SET_SECURE;
      CMD_GET_SECURE:  ffp_decode = OP_GET_SECURE;
      CMD_WRITE_MEM:   ffp_decode = OP_WRITE_MEMORY;
      CMD_SEL_CTRL:    ffp_decode = OP_SELECT_CTRL;
      CMD_GET_VERSION: ffp_decode = OP_GET_VERSION;
      default:         ffp_decode = OP_NONE;
    endcase
  endfunction

  function automatic logic ffp_is_read(input ffp_op_t op);
    ffp_is_read = (op == OP_READ) || (op == OP_GET_LOCK) ||
                  (op == OP_GET_CONFIG) || (op == OP_GET_SECURE) ||
                  (op == OP_GET_VERSION);
  endfunction

  ffp_dstate_t       state_r;
  ffp_dstate_t       state_nxt;
  logic [1:0]        strobe_sync_r;
  logic [1:0]        oe_sync_r;
  logic [2:0]        ext_sync_r;
  logic [3:0]        sel_r;
  logic [DW-1:0]     word_r;
  logic [AW-1:0]     addr_r;
  logic              ready_r;
  logic              drive_r;
  logic [DW-1:0]     dout_r;
  logic              rd_req_r;
  logic              clk_locked_r;
  logic [15:0]       win_cnt_r;
  logic [1:0]        edge_cnt_r;
  logic              ext_ok_r;
  logic [EW-1:0]     mem_r [DEPTH];
  logic [PW-1:0]     wr_ptr_r;
  logic [PW-1:0]     rd_ptr_r;
  logic [PW:0]       count_r;
  logic              strobe_low;
  logic              oe_low;
  logic              fifo_in_ready;
  logic              push;
  logic              pop;
  logic              capture;
  logic              load_cmd;
  logic              rd_done;

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strobe_sync_r <= 2'h3;
      oe_sync_r     <= 2'h3;
      ext_sync_r    <= 3'h0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[0], LINK.command_strobe_n};
      oe_sync_r     <= {oe_sync_r[0], LINK.read_enable_n};
      ext_sync_r    <= {ext_sync_r[1:0], EXT_CLOCK_IN};
    end
  end

  assign strobe_low = !strobe_sync_r[1];
  assign oe_low     = !oe_sync_r[1];

  // ------------------------------------------------------------------
  // Handshake sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    capture   = 1'b0;
    load_cmd  = 1'b0;
    push      = 1'b0;
    rd_done   = 1'b0;
    case (state_r)
      D_IDLE: begin
        if (strobe_low) begin
          capture   = 1'b1;
          state_nxt = D_EXEC;
        end
      end
      D_EXEC: begin
        case (sel_r)
          SEL_COMMAND: begin
            // Pending writes drain before the new command takes over
            if (count_r == '0) begin
              load_cmd  = 1'b1;
              state_nxt = D_WAIT_HI;
            end
          end
          SEL_DATA: begin
            if (ffp_is_read(CMD_OP)) begin
              state_nxt = D_RD_OE;
            end else if (fifo_in_ready) begin
              push      = 1'b1;
              state_nxt = D_WAIT_HI;
            end
          end
          default: state_nxt = D_WAIT_HI;
        endcase
      end
      D_RD_OE:   if (oe_low) state_nxt = D_RD_WAIT;
      D_RD_WAIT: if (RD_ACK) state_nxt = D_RD_DRV;
      D_RD_DRV: begin
        if (!oe_low) begin
          rd_done   = 1'b1;
          state_nxt = D_WAIT_HI;
        end
      end
      D_WAIT_HI: if (!strobe_low) state_nxt = D_IDLE;
      default:   state_nxt = D_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r  <= D_IDLE;
      ready_r  <= 1'b1;
      drive_r  <= 1'b0;
      dout_r   <= '0;
      rd_req_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      rd_req_r <= (state_r == D_RD_OE) && oe_low;
      if (capture) begin
        ready_r <= 1'b0;
      end else if (state_r == D_WAIT_HI && !strobe_low) begin
        ready_r <= 1'b1;
      end
      if (state_r == D_RD_WAIT && RD_ACK) begin
        drive_r <= 1'b1;
        dout_r  <= RD_DATA;
      end else if (rd_done) begin
        drive_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Captured fields, command and address
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_r    <= 4'hf;
      word_r   <= '0;
      CMD_WORD <= '0;
      CMD_OP   <= OP_NONE;
      addr_r   <= '0;
    end else begin
      if (capture) begin
        sel_r  <= LINK.field_selector;
        word_r <= LINK.program_bus;
      end
      if (load_cmd) begin
        CMD_WORD <= word_r;
        CMD_OP   <= ffp_decode(word_r);
      end
      if (state_r == D_EXEC && sel_r == SEL_ADDRESS_LOW) begin
        addr_r[15:0] <= word_r;
      end else if (state_r == D_EXEC && sel_r == SEL_ADDRESS_HIGH) begin
        addr_r[AW-1:16] <= word_r[AW-17:0];
      end else if (push || rd_done) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Two-entry write buffer; a stalled consumer holds ready low
  // ------------------------------------------------------------------
  assign fifo_in_ready = (count_r != DEPTH[PW:0]);
  assign pop           = OP_VALID && OP_READY;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= {CMD_OP, addr_r, word_r};
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

  assign OP_VALID = (count_r != '0);
  assign OP_CODE  = ffp_op_t'(mem_r[rd_ptr_r][EW-1 -: 5]);
  assign OP_ADDR  = mem_r[rd_ptr_r][DW +: AW];
  assign OP_DATA  = mem_r[rd_ptr_r][DW-1:0];

  // ------------------------------------------------------------------
  // External clock detection and latched select
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      win_cnt_r    <= '0;
      edge_cnt_r   <= '0;
      ext_ok_r     <= 1'b0;
      clk_locked_r <= 1'b0;
      CLK_SEL_EXT  <= 1'b0;
    end else begin
      if (win_cnt_r == 16'(EXT_WIN_CYC - 1)) begin
        win_cnt_r  <= '0;
        edge_cnt_r <= '0;
        ext_ok_r   <= (edge_cnt_r == 2'h2);
      end else begin
        win_cnt_r <= win_cnt_r + 1'b1;
        if (ext_sync_r[2:1] == 2'b01 && edge_cnt_r != 2'h2) begin
          edge_cnt_r <= edge_cnt_r + 1'b1;
        end
      end
      // Decided once, on the same edge where ready first falls
      if (capture && !clk_locked_r) begin
        clk_locked_r <= 1'b1;
        CLK_SEL_EXT  <= ext_ok_r;
      end
    end
  end

  assign LINK.device_ready_flag = ready_r;
  assign LINK.dev_bus_oe        = drive_r;
  assign LINK.dev_bus_out       = dout_r;
  assign LINK.bus_drive_flag_n  = !drive_r;
  assign RD_REQ                 = rd_req_r;
  assign RD_OP                  = CMD_OP;
  assign RD_ADDR                = addr_r;
  assign IO_PULLUP_EN           = '1;
  assign IO_OE                  = '0;

endmodule
`default_nettype wire

// [verilog/ffp_pkg.sv]
package ffp_pkg;

  // ------------------------------------------------------------------
  // Field selector codes
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_COMMAND      = 4'h0;
  localparam logic [3:0] SEL_ADDRESS_LOW  = 4'h1;
  localparam logic [3:0] SEL_ADDRESS_HIGH = 4'h2;
  localparam logic [3:0] SEL_DATA         = 4'h5;

  // ------------------------------------------------------------------
  // Command words
  // ------------------------------------------------------------------
  localparam logic [15:0] CMD_READ        = 16'h0011;
  localparam logic [15:0] CMD_WRITE_PAGE  = 16'h0012;
  localparam logic [15:0] CMD_WP_LOCK     = 16'h0022;
  localparam logic [15:0] CMD_ERASE_WP    = 16'h0032;
  localparam logic [15:0] CMD_ERASE_WP_LK = 16'h0042;
  localparam logic [15:0] CMD_ERASE_ALL   = 16'h0013;
  localparam logic [15:0] CMD_SET_LOCK    = 16'h0014;
  localparam logic [15:0] CMD_CLEAR_LOCK  = 16'h0024;
  localparam logic [15:0] CMD_GET_LOCK    = 16'h0015;
  localparam logic [15:0] CMD_SET_CONFIG  = 16'h0034;
  localparam logic [15:0] CMD_CLR_CONFIG  = 16'h0044;
  localparam logic [15:0] CMD_GET_CONFIG  = 16'h0025;
  localparam logic [15:0] CMD_SET_SECURE  = 16'h0054;
  localparam logic [15:0] CMD_GET_SECURE  = 16'h0035;
  localparam logic [15:0] CMD_WRITE_MEM   = 16'h001f;
  localparam logic [15:0] CMD_SEL_CTRL    = 16'h0016;
  localparam logic [15:0] CMD_GET_VERSION = 16'h001e;

  typedef enum logic [4:0] {
    OP_NONE            = 5'h00,
    OP_READ            = 5'h01,
    OP_WRITE_PAGE      = 5'h02,
    OP_WRITE_PAGE_LOCK = 5'h03,
    OP_ERASE_WRITE     = 5'h04,
    OP_ERASE_WRITE_LK  = 5'h05,
    OP_ERASE_ALL       = 5'h06,
    OP_SET_LOCK        = 5'h07,
    OP_CLEAR_LOCK      = 5'h08,
    OP_GET_LOCK        = 5'h09,
    OP_SET_CONFIG      = 5'h0a,
    OP_CLEAR_CONFIG    = 5'h0b,
    OP_GET_CONFIG      = 5'h0c,
    OP_SET_SECURE      = 5'h0d,
    OP_GET_SECURE      = 5'h0e,
    OP_WRITE_MEMORY    = 5'h0f,
    OP_SELECT_CTRL     = 5'h10,
    OP_GET_VERSION     = 5'h11
  } ffp_op_t;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int EXT_CLK_MIN_HZ = 32_000;
  // Window in which two ext clock edges prove a clock above the minimum
  localparam int EXT_WIN_CYC    = CLK_HZ / EXT_CLK_MIN_HZ;
  localparam int POR_WAIT_CYC   = 64;

endpackage

// [verilog/ffp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ffp_if;
  logic        command_strobe_n;
  logic        read_enable_n;
  logic        device_ready_flag;
  logic        bus_drive_flag_n;
  logic [3:0]  field_selector;
  logic [15:0] host_bus_out;
  logic        host_bus_oe;
  logic [15:0] dev_bus_out;
  logic        dev_bus_oe;
  logic [15:0] program_bus;

  // ------------------------------------------------------------------
  // Wire resolution; undriven bus floats high on the pull-ups
  // ------------------------------------------------------------------
  assign program_bus = dev_bus_oe  ? dev_bus_out  :
                       host_bus_oe ? host_bus_out : 16'hffff;

  modport device (
    input  command_strobe_n, read_enable_n, field_selector, program_bus,
    output device_ready_flag, bus_drive_flag_n, dev_bus_out, dev_bus_oe
  );
  modport programmer (
    input  device_ready_flag, bus_drive_flag_n, program_bus,
    output command_strobe_n, read_enable_n, field_selector,
    output host_bus_out, host_bus_oe
  );
endinterface
`default_nettype wire

// [verilog/ffp_programmer.sv]
`timescale 1ns/1ps
`default_nettype none
module ffp_programmer
  import ffp_pkg::*;
#(
  parameter int POR_CYC = POR_WAIT_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  ffp_if.programmer        LINK,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic        REQ_READ,
  input  wire logic [3:0]  REQ_SEL,
  input  wire logic [15:0] REQ_DATA,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA
);

  typedef enum logic [2:0] {
    P_POR    = 3'b000,
    P_IDLE   = 3'b001,
    P_SETUP  = 3'b010,
    P_STROBE = 3'b011,
    P_RD_OE  = 3'b100,
    P_RD_REL = 3'b101,
    P_END    = 3'b110
  } ffp_pstate_t;

  ffp_pstate_t  state_r;
  logic [15:0]  por_cnt_r;
  logic         read_r;
  logic [3:0]   sel_r;
  logic [15:0]  data_r;
  logic         strobe_n_r;
  logic         oe_n_r;
  logic         bus_oe_r;

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  assign REQ_READY = (state_r == P_IDLE) && LINK.device_ready_flag;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= P_POR;
      por_cnt_r  <= '0;
      read_r     <= 1'b0;
      sel_r      <= 4'hf;
      data_r     <= '0;
      strobe_n_r <= 1'b1;
      oe_n_r     <= 1'b1;
      bus_oe_r   <= 1'b0;
      RSP_VALID  <= 1'b0;
      RSP_DATA   <= '0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_r)
        P_POR: begin
          por_cnt_r <= por_cnt_r + 1'b1;
          if (por_cnt_r == 16'(POR_CYC - 1)) state_r <= P_IDLE;
        end
        P_IDLE: begin
          if (REQ_VALID && REQ_READY) begin
            read_r   <= REQ_READ;
            sel_r    <= REQ_SEL;
            data_r   <= REQ_DATA;
            bus_oe_r <= 1'b1;
            state_r  <= P_SETUP;
          end
        end
        P_SETUP: begin
          strobe_n_r <= 1'b0;
          state_r    <= P_STROBE;
        end
        P_STROBE: begin
          if (!LINK.device_ready_flag) begin
            bus_oe_r <= 1'b0;
            if (read_r) begin
              state_r <= P_RD_OE;
            end else begin
              strobe_n_r <= 1'b1;
              state_r    <= P_END;
            end
          end
        end
        P_RD_OE: begin
          oe_n_r <= 1'b0;
          if (!oe_n_r && !LINK.bus_drive_flag_n) begin
            RSP_DATA <= LINK.program_bus;
            oe_n_r   <= 1'b1;
            state_r  <= P_RD_REL;
          end
        end
        P_RD_REL: begin
          if (LINK.bus_drive_flag_n) begin
            strobe_n_r <= 1'b1;
            state_r    <= P_END;
          end
        end
        P_END: begin
          if (LINK.device_ready_flag) begin
            RSP_VALID <= read_r;
            state_r   <= P_IDLE;
          end
        end
        default: state_r <= P_IDLE;
      endcase
    end
  end

  assign LINK.command_strobe_n = strobe_n_r;
  assign LINK.read_enable_n    = oe_n_r;
  assign LINK.field_selector   = sel_r;
  assign LINK.host_bus_out     = data_r;
  assign LINK.host_bus_oe      = bus_oe_r;

endmodule
`default_nettype wire

// [test/ffp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ffp_properties (
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic        command_strobe_n,
  input wire logic        read_enable_n,
  input wire logic        device_ready_flag,
  input wire logic        bus_drive_flag_n,
  input wire logic [3:0]  field_selector,
  input wire logic        host_bus_oe,
  input wire logic        dev_bus_oe,
  input wire logic [15:0] program_bus
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  property p_start_ready;
    $fell(command_strobe_n) |-> device_ready_flag;
  endproperty
  a_start_ready: assert property (p_start_ready)
    else $error("strobe fell while busy");

  property p_hold_request;
    !command_strobe_n && device_ready_flag |=>
      $stable(field_selector) && $stable(program_bus);
  endproperty
  a_hold_request: assert property (p_hold_request)
    else $error("request changed before ready fell");

  property p_ready_answer;
    $fell(command_strobe_n) |-> ##[1:4] !device_ready_flag;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("ready did not fall after strobe");

  property p_busy_min;
    $fell(device_ready_flag) |-> !device_ready_flag [*3];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("ready rose too early");

  // Two-flop sync: strobe must have been high for three samples
  property p_ready_after_strobe;
    $rose(device_ready_flag) |->
      command_strobe_n && $past(command_strobe_n)
      && $past(command_strobe_n, 2);
  endproperty
  a_ready_after_strobe: assert property (p_ready_after_strobe)
    else $error("ready rose while strobe low");

  property p_idle_stays;
    device_ready_flag && command_strobe_n |=> device_ready_flag;
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("ready dropped without request");

  // ----------------------------------------------------------------
  // Bus direction
  // ----------------------------------------------------------------
  property p_no_clash;
    !(dev_bus_oe && host_bus_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the bus");

  property p_flag_dir;
    bus_drive_flag_n == !dev_bus_oe;
  endproperty
  a_flag_dir: assert property (p_flag_dir)
    else $error("drive flag disagrees with bus direction");

  property p_drive_start;
    $rose(dev_bus_oe) |-> !read_enable_n && !$past(read_enable_n)
      && !device_ready_flag;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("bus driven outside read enable");

  property p_drive_stop;
    $rose(read_enable_n) |-> ##[1:4] !dev_bus_oe && bus_drive_flag_n;
  endproperty
  a_drive_stop: assert property (p_drive_stop)
    else $error("bus not released after read enable");
endmodule
`default_nettype wire

// [test/parallel_flash_program_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_program_port_tb_top import ffp_pkg::*;;
  typedef struct packed {
    ffp_op_t     op;
    logic [31:0] addr;
    logic [15:0] data;
  } ffp_entry_t;
  logic        mclk, reset_n, ext_clk, op_ready, rd_ack, rd_req, rd_pend;
  logic        req_valid, req_read, req_ready, rsp_valid, clk_sel_ext;
  logic        op_valid, ext_en;
  logic [3:0]  req_sel;
  logic [15:0] req_data, rsp_data, rd_data, cmd_word, op_data, q, w, d;
  logic [31:0] op_addr, rd_addr, base, rnd;
  logic [7:0]  io_pullup_en, io_oe;
  ffp_op_t     cmd_op, op_code, rd_op, rd_op_exp;
  ffp_entry_t  exp_q[$];
  integer      seed;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;
  int          ext_div = 0;
  logic [15:0] cmd_w[18] = '{CMD_READ, CMD_WRITE_PAGE, CMD_WP_LOCK,
    CMD_ERASE_WP, CMD_ERASE_WP_LK, CMD_ERASE_ALL, CMD_SET_LOCK,
    CMD_CLEAR_LOCK, CMD_GET_LOCK, CMD_SET_CONFIG, CMD_CLR_CONFIG,
    CMD_GET_CONFIG, CMD_SET_SECURE, CMD_GET_SECURE, CMD_WRITE_MEM,
    CMD_SEL_CTRL, CMD_GET_VERSION, 16'h0099};
  ffp_op_t     cmd_o[18] = '{OP_READ, OP_WRITE_PAGE, OP_WRITE_PAGE_LOCK,
    OP_ERASE_WRITE, OP_ERASE_WRITE_LK, OP_ERASE_ALL, OP_SET_LOCK,
    OP_CLEAR_LOCK, OP_GET_LOCK, OP_SET_CONFIG, OP_CLEAR_CONFIG,
    OP_GET_CONFIG, OP_SET_SECURE, OP_GET_SECURE, OP_WRITE_MEMORY,
    OP_SELECT_CTRL, OP_GET_VERSION, OP_NONE};
  int          rd_idx[5] = '{0, 8, 11, 13, 16};

  ffp_if lnk ();
  ffp_device ffp_device_i (.MCLK(mclk), .RESET_N(reset_n), .LINK(lnk),
    .EXT_CLOCK_IN(ext_clk), .CLK_SEL_EXT(clk_sel_ext),
    .IO_PULLUP_EN(io_pullup_en), .IO_OE(io_oe), .CMD_OP(cmd_op),
    .CMD_WORD(cmd_word), .OP_VALID(op_valid), .OP_READY(op_ready),
    .OP_CODE(op_code), .OP_ADDR(op_addr), .OP_DATA(op_data),
    .RD_REQ(rd_req), .RD_OP(rd_op), .RD_ADDR(rd_addr), .RD_ACK(rd_ack),
    .RD_DATA(rd_data));
  // Short power-on wait keeps the run brief
  ffp_programmer #(.POR_CYC(4)) ffp_programmer_i (.MCLK(mclk),
    .RESET_N(reset_n), .LINK(lnk), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_READ(req_read), .REQ_SEL(req_sel),
    .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  ffp_properties ffp_properties_i (.MCLK(mclk), .RESET_N(reset_n),
    .command_strobe_n(lnk.command_strobe_n),
    .read_enable_n(lnk.read_enable_n),
    .device_ready_flag(lnk.device_ready_flag),
    .bus_drive_flag_n(lnk.bus_drive_flag_n),
    .field_selector(lnk.field_selector), .host_bus_oe(lnk.host_bus_oe),
    .dev_bus_oe(lnk.dev_bus_oe), .program_bus(lnk.program_bus));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [15:0] rd_word(input logic [31:0] a);
    return a[15:0] ^ a[31:16] ^ 16'h5a3c;
  endfunction

  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Flash back end, external clock, write stream monitor
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    rnd = $random(seed);
    cycles <= cycles + 1;
    op_ready <= rnd[0];
    // 200 cycle period, well above the minimum rate
    ext_div <= (ext_div == 99) ? 0 : ext_div + 1;
    if (ext_div == 99 && ext_en)
      ext_clk <= ~ext_clk;
    rd_ack <= rd_pend && rnd[1];
    rd_data <= (rd_pend && rnd[1]) ? rd_word(rd_addr) : ~rd_data;
    if (rd_req === 1'b1) begin
      rd_pend <= 1'b1;
      chk(rd_op === rd_op_exp, "read op code");
    end else if (rd_pend && rnd[1]) begin
      rd_pend <= 1'b0;
    end
    if (reset_n && op_valid === 1'b1 && op_ready) begin
      chk(exp_q.size() != 0 && {op_code, op_addr, op_data} === exp_q[0],
          "write entry");
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic xfer(input logic rd, input logic [3:0] sel,
                      input logic [15:0] dat);
    int n;
    bit got;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_sel <= sel;
    req_data <= dat;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    got = 0;
    do begin
      @(posedge mclk);
      n++;
      if (rsp_valid === 1'b1) begin
        q = rsp_data;
        got = 1;
      end
    end while (!(rd ? got : req_ready === 1'b1) && n < 800);
    chk(n < 800, "handshake stalled");
  endtask

  initial begin
    seed = 32'h2d0d9fc3;
    {reset_n, req_valid, req_read, ext_clk, op_ready, rd_ack} = '0;
    {rd_pend, req_sel, req_data, rd_data} = '0;
    ext_en = 1'b1;
    rd_op_exp = OP_NONE;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    // Clock decision needs one full detection window first
    repeat (1300) @(posedge mclk);
    chk(io_pullup_en === 8'hff && io_oe === 8'h00, "spare pins");
    for (int i = 0; i < 18; i++) begin
      xfer(1'b0, SEL_COMMAND, cmd_w[i]);
      chk(cmd_word === cmd_w[i], "command word");
      chk(cmd_op === cmd_o[i], "command decode");
      chk(clk_sel_ext === 1'b1, "external clock");
    end
    // Write streams; first one crosses the low address word boundary
    for (int i = 1; i < 5; i++) begin
      base = $random(seed);
      if (i == 1)
        base[15:0] = 16'hfffe;
      xfer(1'b0, SEL_COMMAND, cmd_w[i]);
      xfer(1'b0, SEL_ADDRESS_LOW, base[15:0]);
      w = cmd_word;
      xfer(1'b0, (i == 1) ? 4'hf : 4'h6 + 4'(rnd[2:0]), 16'h0000);
      chk(cmd_word === w, "idle selector");
      xfer(1'b0, SEL_ADDRESS_HIGH, base[31:16]);
      for (int j = 0; j < 3; j++) begin
        d = $random(seed);
        exp_q.push_back('{cmd_o[i], base + j, d});
        xfer(1'b0, SEL_DATA, d);
      end
    end
    for (int i = 0; i < 5; i++) begin
      base = $random(seed);
      rd_op_exp = cmd_o[rd_idx[i]];
      xfer(1'b0, SEL_COMMAND, cmd_w[rd_idx[i]]);
      chk(i != 0 || exp_q.size() == 0, "buffer flushed");
      xfer(1'b0, SEL_ADDRESS_LOW, base[15:0]);
      xfer(1'b0, SEL_ADDRESS_HIGH, base[31:16]);
      for (int j = 0; j < 2; j++) begin
        xfer(1'b1, SEL_DATA, 16'h0000);
        chk(q === rd_word(base + j), "read data");
      end
    end
    // Mid-run reset with the external clock stopped
    repeat (20) @(posedge mclk);
    ext_en <= 1'b0;
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(cmd_op === OP_NONE && lnk.device_ready_flag === 1'b1,
        "reset state");
    reset_n <= 1'b1;
    repeat (1300) @(posedge mclk);
    xfer(1'b0, SEL_COMMAND, CMD_READ);
    chk(clk_sel_ext === 1'b0, "no external clock");
    chk(cmd_op === OP_READ, "decode after reset");
    repeat (20) @(posedge mclk);
    summarize();
  end
endmodule
`default_nettype wire
